//--- periph_reg_bank.sv
// peripheral register front end with interrupt mask
// and four transfer channels
// assumes: one register bus master on ref_clk, word data, 16 KB window
//
// Our own choices: the plain strobed port and the address map.
`include "periph_params.svh"
module periph_reg_bank
    import periph_pkg::*;
#(
    parameter int NUM_CHAN = 4,
    parameter int PTR_W    = 32,
    parameter int CNT_W    = 16
) (
    input  wire logic                           ref_clk,
    input  wire logic                           rst,
    input  wire periph_pkg::bus_req_t           bus,
    input  wire logic [NUM_CHAN-1:0]            xfer_req,
    output logic      [31:0]                    rdata_q,
    output logic                                irq_q,
    output logic      [NUM_CHAN-1:0]            active_q,
    output logic      [NUM_CHAN-1:0][PTR_W-1:0] xfer_ptr_q
);
    import periph_pkg::*;

    reg_state_t q;
    reg_state_t d;

    logic [13:0]                    word_addr;
    logic                           ctrl_wr;
    logic                           abort;
    logic [2:0]                     step;
    logic [NUM_CHAN-1:0]            done;
    logic [NUM_CHAN-1:0]            cnt_zero;
    logic [NUM_CHAN-1:0][CNT_W-1:0] cnt;
    logic [NUM_CHAN-1:0][31:0]      chan_rd;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // byte lanes do not exist, so the two low bits are simply dropped
    // fourteen address bits span the whole 16 KB window
    assign word_addr = {bus.addr[13:`WORD_LSB], 2'b00};
    assign ctrl_wr   = bus.wr && (word_addr == `REG_CTRL);
    assign abort     = ctrl_wr && bus.wdata[`CTRL_ABORT];
    // byte 1, half word 2, word 4
    assign step      = 3'(1) << q.mode;

    // ----------------------------------------------------------------
    // transfer channels, receive then transmit for each port
    // ----------------------------------------------------------------
    // channel 2k is receive of port k, channel 2k+1 is its transmit
    for (genvar i = 0; i < NUM_CHAN; i++)
    begin : g_chan
        localparam logic [13:0] PTR_OFS = `REG_CHAN_BASE + 14'(i) * `REG_CHAN_STRIDE;
        localparam logic [13:0] CNT_OFS = PTR_OFS + `REG_CNT_OFS;

        logic ptr_hit;
        logic cnt_hit;
        logic [PTR_W-1:0] ptr;

        assign ptr_hit = (word_addr == PTR_OFS);
        assign cnt_hit = (word_addr == CNT_OFS);

        xfer_channel #(
            .PTR_W    (PTR_W),
            .CNT_W    (CNT_W)
        ) u_chan (
            .ref_clk  (ref_clk),
            .rst      (rst),
            .ptr_we   (bus.wr && ptr_hit),
            .cnt_we   (bus.wr && cnt_hit),
            .wdata    (bus.wdata),
            .abort    (abort),
            .enable   (q.sstat[i]),
            .req      (xfer_req[i]),
            .step     (step),
            .ptr_q    (ptr),
            .cnt_q    (cnt[i]),
            .active_q (active_q[i]),
            .done_q   (done[i])
        );

        assign xfer_ptr_q[i] = ptr;
        assign cnt_zero[i]   = (cnt[i] == '0);
        // counter sits in the low half, upper bits read zero
        assign chan_rd[i]    = ptr_hit ? 32'(ptr) :
                               cnt_hit ? 32'(cnt[i]) : 32'h0000_0000;
    end

    // ----------------------------------------------------------------
    // register next state
    // ----------------------------------------------------------------
    always_comb
    begin
        d       = q;
        d.rdata = 32'h0000_0000;

        // writes; status and unmapped offsets fall through untouched
        if (bus.wr)
        begin
            if (word_addr == `REG_MODE)
                d.mode = xfer_size_t'(bus.wdata[1:0]);
            else if (word_addr == `REG_SEN)
                d.sstat = q.sstat | bus.wdata[3:0];
            else if (word_addr == `REG_SDIS)
                d.sstat = q.sstat & ~bus.wdata[3:0];
            else if (word_addr == `REG_IER)
                d.imr = q.imr | bus.wdata[3:0];
            else if (word_addr == `REG_IDR)
                d.imr = q.imr & ~bus.wdata[3:0];
            else if (word_addr == `REG_EVT)
                d.evt = q.evt & ~bus.wdata[3:0];
            else if (ctrl_wr && bus.wdata[`CTRL_CLR_EVT])
                d.evt = 4'h0;
        end

        // a completion in the clearing cycle must not be lost
        d.evt = d.evt | done;

        // reads answer one cycle later; control reads as zero
        if (bus.rd)
        begin
            if (word_addr == `REG_MODE)
                d.rdata = {30'h0000_0000, q.mode};
            else if (word_addr == `REG_SSTAT)
                d.rdata = {28'h000_0000, q.sstat};
            else if (word_addr == `REG_STATUS)
                d.rdata = {24'h00_0000, cnt_zero, active_q};
            else if (word_addr == `REG_IMR)
                d.rdata = {28'h000_0000, q.imr};
            else if (word_addr == `REG_EVT)
                d.rdata = {28'h000_0000, q.evt};
            else
            begin
                for (int k = 0; k < NUM_CHAN; k++)
                    d.rdata = d.rdata | chan_rd[k];
            end
        end

        // registered so the output is glitch free toward the controller
        d.irq = |(d.evt & d.imr);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            q       <= '0;
            q.mode  <= xfer_size_t'(`MODE_RST);
            q.imr   <= `IMR_RST;
            q.sstat <= `SSTAT_RST;
        end
        else
            q <= d;
    end

    assign rdata_q = q.rdata;
    assign irq_q   = q.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // reset values checked outside the disable
    a_mode_reset: assert property (disable iff (1'b0) rst |=> q.mode == SZ_BYTE)
        else $error("mode not zero after reset");
    a_mask_reset: assert property (disable iff (1'b0) rst |=> q.imr == 4'h0 && !irq_q)
        else $error("mask or interrupt set after reset");

    a_enable_sets: assert property (bus.wr && word_addr == `REG_SEN
        |=> q.sstat == ($past(q.sstat) | $past(bus.wdata[3:0])))
        else $error("enable write did not set exactly the written bits");
    a_disable_clears: assert property (bus.wr && word_addr == `REG_SDIS
        |=> q.sstat == ($past(q.sstat) & ~$past(bus.wdata[3:0])))
        else $error("disable write did not clear exactly the written bits");

    a_irq_masked: assert property (##1 irq_q == |(q.evt & q.imr))
        else $error("interrupt does not match masked status");
    a_mask_by_set_clr: assert property (!$stable(q.imr)
        |-> $past(bus.wr) && ($past(word_addr) == `REG_IER || $past(word_addr) == `REG_IDR))
        else $error("mask changed without a set or clear write");

    a_end_sets_evt: assert property (done != '0 |=> (q.evt & $past(done)) == $past(done))
        else $error("end of transfer did not set its event");
    a_mode_word_read: assert property (bus.rd && word_addr == `REG_MODE
        |=> rdata_q == {30'h0000_0000, $past(q.mode)})
        else $error("mode read wrong or upper bits not zero");
    a_ctrl_reads_zero: assert property (bus.rd && word_addr == `REG_CTRL |=> rdata_q == 32'h0000_0000)
        else $error("control register read returned data");
    a_status_ro: assert property (bus.wr && word_addr == `REG_STATUS
        |=> $stable(q.sstat) && $stable(q.imr) && $stable(q.mode))
        else $error("write to status changed state");
    a_rdata_one_cycle: assert property (!bus.rd |=> rdata_q == 32'h0000_0000)
        else $error("read data outside the answer cycle");

    c_irq_raised: cover property (!irq_q ##1 irq_q);
    c_chan_done: cover property (done != '0);
    c_set_clear_same: cover property (bus.wr && word_addr == `REG_EVT && done != '0);
endmodule

//--- periph_params.svh
// constants for the peripheral register front end
// assumes: included by the package and by the register bank module
`ifndef PERIPH_PARAMS_SVH
`define PERIPH_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets within the 16 KB window
// ----------------------------------------------------------------
`define REG_CTRL        14'h0000
`define REG_MODE        14'h0004
`define REG_SEN         14'h0008
`define REG_SDIS        14'h000C
`define REG_SSTAT       14'h0010
`define REG_STATUS      14'h0014
`define REG_IER         14'h0018
`define REG_IDR         14'h001C
`define REG_IMR         14'h0020
`define REG_EVT         14'h0024
`define REG_CHAN_BASE   14'h0030
`define REG_CHAN_STRIDE 14'h0008
`define REG_CNT_OFS     14'h0004

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CTRL_CLR_EVT    0
`define CTRL_ABORT      1
`define STAT_END_LSB    4
`define MODE_RST        2'h0
`define IMR_RST         4'h0
`define SSTAT_RST       4'h0
`define WORD_LSB        2

`endif

//--- periph_pkg.sv
// types shared by the peripheral register front end
// assumes: periph_params.svh is on the include path
package periph_pkg;
`include "periph_params.svh"

    // one register bus request, one cycle long
    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [13:0] addr;
        logic [31:0] wdata;
    } bus_req_t;

    // transfer unit size held in the mode register
    typedef enum logic [1:0]
    {
        SZ_BYTE = 2'b00,
        SZ_HALF = 2'b01,
        SZ_WORD = 2'b10
    } xfer_size_t;

    // register state of the front end apart from the channel pointers and counters
    typedef struct packed
    {
        xfer_size_t  mode;
        logic [3:0]  sstat;
        logic [3:0]  imr;
        logic [3:0]  evt;
        logic [31:0] rdata;
        logic        irq;
    } reg_state_t;
endpackage

//--- xfer_channel.sv
// one data transfer channel: address pointer and transfer counter
// assumes: req comes from logic on the same clock, one pulse per transfer
module xfer_channel #(
    parameter int PTR_W = 32,
    parameter int CNT_W = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             ptr_we,
    input  wire logic             cnt_we,
    input  wire logic [31:0]      wdata,
    input  wire logic             abort,
    input  wire logic             enable,
    input  wire logic             req,
    input  wire logic [2:0]       step,
    output logic      [PTR_W-1:0] ptr_q,
    output logic      [CNT_W-1:0] cnt_q,
    output logic                  active_q,
    output logic                  done_q
);
    typedef struct packed
    {
        logic [PTR_W-1:0] ptr;
        logic [CNT_W-1:0] cnt;
        logic             active;
        logic             done;
    } chan_st_t;

    chan_st_t q;
    chan_st_t d;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // software writes win over a transfer in the same cycle
    always_comb
    begin
        d      = q;
        d.done = 1'b0;
        if (ptr_we)
            d.ptr = wdata[PTR_W-1:0];
        if (cnt_we)
            d.cnt = wdata[CNT_W-1:0];
        else if (abort)
            d.cnt = '0;
        else if (req && q.active)
        begin
            d.ptr  = ptr_we ? wdata[PTR_W-1:0] : q.ptr + PTR_W'(step);
            d.cnt  = q.cnt - CNT_W'(1);
            d.done = (q.cnt == CNT_W'(1));
        end
        d.active = enable && (d.cnt != '0);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    assign ptr_q    = q.ptr;
    assign cnt_q    = q.cnt;
    assign active_q = q.active;
    assign done_q   = q.done;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_cnt_step_down: assert property (req && active_q && !cnt_we && !abort |=> cnt_q == $past(cnt_q) - CNT_W'(1))
        else $error("counter did not step down after a transfer");
    a_zero_holds: assert property (cnt_q == '0 && !cnt_we && !ptr_we |=> cnt_q == '0 && $stable(ptr_q) && !active_q)
        else $error("channel moved while its counter was zero");
endmodule

//--- srl_port_model.sv
// serial port side model: raises per channel transfer requests
// assumes: same clock as the register bank, run set by the bench
module srl_port_model (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [3:0] run,
    input  wire logic       fast,
    output logic      [3:0] xfer_req
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // request pacing
    // ----------------------------------------------------------------
    logic tgl_q;

    // slow mode asks every other cycle, fast mode every cycle
    // ch0/ch1 rx/tx of port 0, ch2/ch3 rx/tx of port 1
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            tgl_q    <= 1'b0;
            xfer_req <= 4'h0;
        end
        else
        begin
            tgl_q    <= ~tgl_q;
            xfer_req <= run & {4{fast | tgl_q}};
        end
    end
endmodule

//--- peripheral_reg_irq_dma_tb.sv
// self-checking bench for the register front end and its channels
// assumes: srl_port_model drives the transfer requests
module peripheral_reg_irq_dma_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import periph_pkg::*;

    typedef struct { logic [13:0] wa; logic [31:0] wd; logic [13:0] ra; logic [31:0] ex; } row_t;

    logic                  ref_clk = 1'b0;
    logic                  rst     = 1'b1;
    bus_req_t              bus     = '0;
    logic       [3:0]      run     = 4'h0;
    logic                  fast    = 1'b0;
    logic       [3:0]      xfer_req;
    logic       [31:0]     rdata_q;
    logic                  irq_q;
    logic       [3:0]      active_q;
    logic       [3:0][31:0] xfer_ptr_q;
    logic       [31:0]     v;
    int                    n_fail = 0;
    int                    check_count = 0;
    int                    cyc = 0;

    // ordinary register cases: write, then read back
    row_t rows [13] = '{
        '{14'h0004, 32'h0000_0002, 14'h0004, 32'h0000_0002},
        '{14'h0008, 32'h0000_0005, 14'h0010, 32'h0000_0005},
        '{14'h0008, 32'h0000_0002, 14'h0010, 32'h0000_0007},
        '{14'h000C, 32'h0000_0006, 14'h0010, 32'h0000_0001},
        '{14'h0010, 32'h0000_000F, 14'h0010, 32'h0000_0001},
        '{14'h0018, 32'h0000_0009, 14'h0020, 32'h0000_0009},
        '{14'h001C, 32'h0000_0008, 14'h0020, 32'h0000_0001},
        '{14'h0020, 32'h0000_000F, 14'h0020, 32'h0000_0001},
        '{14'h0000, 32'h0000_0001, 14'h0000, 32'h0000_0000},
        '{14'h0030, 32'h0000_0100, 14'h0033, 32'h0000_0100},
        '{14'h0034, 32'h0000_0002, 14'h0034, 32'h0000_0002},
        '{14'h3FFC, 32'h0000_0055, 14'h3FFC, 32'h0000_0000},
        '{14'h0048, 32'hFFFF_FFFC, 14'h0048, 32'hFFFF_FFFC}
    };

    periph_reg_bank uut (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .bus        (bus),
        .xfer_req   (xfer_req),
        .rdata_q    (rdata_q),
        .irq_q      (irq_q),
        .active_q   (active_q),
        .xfer_ptr_q (xfer_ptr_q)
    );

    srl_port_model port (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .run      (run),
        .fast     (fast),
        .xfer_req (xfer_req)
    );

    // ----------------------------------------------------------------
    // clock, timeout and shared tasks
    // ----------------------------------------------------------------
    initial
    begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    // a hung wait ends the run here
    always @(posedge ref_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            n_fail = n_fail + 1;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one cycle write strobe, then an idle cycle; returns once the
    // registers launched at the strobe edge have settled
    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus <= {1'b1, 1'b0, a, d};
        @(posedge ref_clk);
        bus <= '0;
        #1;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [13:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        bus <= {1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge ref_clk);
        bus <= '0;
        #1;
        d = rdata_q;
    endtask

    task automatic rdchk(input logic [13:0] a, input logic [31:0] exp);
        logic [31:0] t;
        rd(a, t);
        chk(t, exp);
    endtask

    // let the port model run channel i for 40 cycles, then stop it for 3
    task automatic drain(input int i);
        @(posedge ref_clk);
        run[i] <= 1'b1;
        repeat (40) @(posedge ref_clk);
        run[i] <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rdchk(14'h0020, 32'h0000_0000);
        rdchk(14'h0004, 32'h0000_0000);
        foreach (rows[k])
        begin
            wr(rows[k].wa, rows[k].wd);
            rdchk(rows[k].ra, rows[k].ex);
        end
        // ch0 enabled, count 2, word steps, interrupt masked in
        chk({28'h0, active_q}, 32'h0000_0001);
        wr(14'h0014, 32'h0000_00FF);
        rdchk(14'h0014, 32'h0000_00E1);
        chk({31'h0, irq_q}, 32'h0000_0000);
        drain(0);
        chk(xfer_ptr_q[0], 32'h0000_0108);
        chk({28'h0, active_q}, 32'h0000_0000);
        rdchk(14'h0014, 32'h0000_00F0);
        rdchk(14'h0024, 32'h0000_0001);
        chk({31'h0, irq_q}, 32'h0000_0001);
        // every transfer size on ch1, one transfer each
        for (int k = 0; k < 3; k++)
        begin
            wr(14'h0004, k);
            wr(14'h0038, 32'h0000_0000);
            wr(14'h003C, 32'h0000_0001);
            wr(14'h0008, 32'h0000_0002);
            drain(1);
            chk(xfer_ptr_q[1], 32'h0000_0001 << k);
        end
        // back to back byte transfers on ch2, event masked out
        fast <= 1'b1;
        wr(14'h0004, 32'h0000_0000);
        wr(14'h0040, 32'h0000_0200);
        wr(14'h0044, 32'h0000_0003);
        wr(14'h0008, 32'h0000_0004);
        drain(2);
        chk(xfer_ptr_q[2], 32'h0000_0203);
        wr(14'h0024, 32'h0000_0001);
        chk({31'h0, irq_q}, 32'h0000_0000);
        wr(14'h0018, 32'h0000_0004);
        chk({31'h0, irq_q}, 32'h0000_0001);
        wr(14'h0024, 32'h0000_0004);
        chk({31'h0, irq_q}, 32'h0000_0000);
        // a zero to control does nothing, a one in bit 1 aborts
        wr(14'h004C, 32'h0000_0005);
        wr(14'h0008, 32'h0000_0008);
        wr(14'h0000, 32'h0000_0000);
        rdchk(14'h004C, 32'h0000_0005);
        wr(14'h0000, 32'h0000_0002);
        rdchk(14'h004C, 32'h0000_0000);
        chk({28'h0, active_q}, 32'h0000_0000);
        // second reset in mid run
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rdchk(14'h0020, 32'h0000_0000);
        rdchk(14'h0004, 32'h0000_0000);
        chk(xfer_ptr_q[2], 32'h0000_0000);
        finish_test();
    end
endmodule
